// File: rtl/coarse_stage.v
// Upper comparator group: resolves the upper 4-bit partial result
`timescale 1ns/10ps
`include "two_step_adc_consts.vh"

module coarse_stage #(
  parameter PART_W = `ADC_PART_W,
  parameter FRAC_W = `ADC_FRAC_W,
  parameter LEVEL_W = `ADC_LEVEL_W
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire [LEVEL_W-1:0] i_held_level,
  output reg [PART_W-1:0] o_upper_partial_result_r
);

  localparam COMP_N = (1 << PART_W) - 1;

  // ****************************************
  // Comparator bank against fixed taps
  // ****************************************
  wire [COMP_N-1:0] therm;
  genvar j;
  generate
    for (j = 1; j <= COMP_N; j = j + 1) begin : g_cmp
      localparam integer TAP_I = j << (PART_W + FRAC_W);
      localparam [LEVEL_W-1:0] TAP = TAP_I[LEVEL_W-1:0];
      assign therm[j-1] = (i_held_level >= TAP);
    end
  endgenerate

  // ****************************************
  // Thermometer to binary
  // ****************************************
  reg [PART_W-1:0] upper_nxt;
  integer k;
  always @* begin
    upper_nxt = {PART_W{1'b0}};
    for (k = 0; k < COMP_N; k = k + 1) begin
      if (therm[k]) begin
        upper_nxt = k[PART_W-1:0] + 1'b1;
      end
    end
  end

  // Resolve on the first rising edge after sampling
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_upper_partial_result_r <= {PART_W{1'b0}};
    end else begin
      o_upper_partial_result_r <= upper_nxt;
    end
  end

endmodule

// File: rtl/fine_group.v
// One lower comparator group: holds a sample, resolves lower 4 bits
`timescale 1ns/10ps
`include "two_step_adc_consts.vh"

module fine_group #(
  parameter PART_W = `ADC_PART_W,
  parameter FRAC_W = `ADC_FRAC_W,
  parameter LEVEL_W = `ADC_LEVEL_W
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_take,
  input wire [LEVEL_W-1:0] i_level,
  input wire i_resolve,
  input wire [PART_W-1:0] i_fine_window_reference,
  output reg [PART_W-1:0] o_lower_partial_result_r
);

  localparam COMP_N = (1 << PART_W) - 1;

  // ****************************************
  // Own sample hold, falling edge
  // ****************************************
  reg [LEVEL_W-1:0] held_r;
  always @(negedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      held_r <= {LEVEL_W{1'b0}};
    end else if (i_take) begin
      held_r <= i_level;
    end
  end

  // ****************************************
  // Residue inside the selected window
  // ****************************************
  wire [LEVEL_W-1:0] window_base;
  wire [LEVEL_W-1:0] residue;
  assign window_base = {i_fine_window_reference, {(LEVEL_W-PART_W){1'b0}}};
  assign residue = held_r - window_base;

  wire [COMP_N-1:0] therm;
  genvar j;
  generate
    for (j = 1; j <= COMP_N; j = j + 1) begin : g_cmp
      localparam integer TAP_I = j << FRAC_W;
      localparam [LEVEL_W-1:0] TAP = TAP_I[LEVEL_W-1:0];
      assign therm[j-1] = (residue >= TAP);
    end
  endgenerate

  reg [PART_W-1:0] lower_nxt;
  integer k;
  always @* begin
    lower_nxt = {PART_W{1'b0}};
    for (k = 0; k < COMP_N; k = k + 1) begin
      if (therm[k]) begin
        lower_nxt = k[PART_W-1:0] + 1'b1;
      end
    end
  end

  // Resolve on the second rising edge after sampling
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_lower_partial_result_r <= {PART_W{1'b0}};
    end else if (i_resolve) begin
      o_lower_partial_result_r <= lower_nxt;
    end
  end

endmodule

// File: rtl/two_step_adc_consts.vh
// Constants for the two-step converter output pipeline
`ifndef TWO_STEP_ADC_CONSTS_VH
`define TWO_STEP_ADC_CONSTS_VH

// ****************************************
// Widths
// ****************************************
`define ADC_CODE_W 8
`define ADC_PART_W 4
`define ADC_FRAC_W 4
`define ADC_LEVEL_W 12
`define ADC_COMP_N 15

// ****************************************
// Codes and reset values
// ****************************************
`define ADC_CODE_ZERO 8'h00
`define ADC_CODE_FULL 8'hff
`define ADC_PART_ZERO 4'h0
`define ADC_LEVEL_ZERO 12'h000

// ****************************************
// Timing in clock edges
// ****************************************
`define ADC_RISE_TO_OUT 3
`define ADC_VALID_W 3

`endif

// File: rtl/two_step_adc_output_pipeline.v
// Top of the two-step converter digital pipeline
// Operation
// - Coarse 4-bit upper group plus two separate 4-bit lower groups.
// - All comparator phases run from the one external clock only.
// - A new sample enters the coarse stage on every falling edge.
// - The assigned lower group captures the same sample on that edge.
// - Upper result resolves next rising edge and selects fine window.
// - Assigned lower group resolves on the second rising edge.
// - Merged code reaches the output bus at the third rising edge.
// - Code appears 2.5 cycles after its sampling edge.
// - Lower groups alternate strictly on successive samples.
// - After latency, one new word per cycle, in sample order.
// - Straight binary, MSB on top line, bottom 0, top 255.
// - Every code 0 to 255 is reachable; no missing codes.
`timescale 1ns/10ps
`include "two_step_adc_consts.vh"

module two_step_adc_output_pipeline #(
  parameter CODE_W = `ADC_CODE_W,
  parameter PART_W = `ADC_PART_W,
  parameter FRAC_W = `ADC_FRAC_W,
  parameter LEVEL_W = `ADC_LEVEL_W
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire [LEVEL_W-1:0] i_analog_level,
  input wire i_output_drive_b,
  output reg [CODE_W-1:0] o_sample_code_bits,
  output reg o_sample_code_bits_oe,
  output reg o_code_valid
);

  // ****************************************
  // Falling edge: sample and group choice
  // ****************************************
  reg [LEVEL_W-1:0] coarse_hold_r;
  reg group_sel_r;
  reg taken_grp_r;
  reg sampled_r;
  always @(negedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      coarse_hold_r <= `ADC_LEVEL_ZERO;
      group_sel_r <= 1'b0;
      taken_grp_r <= 1'b0;
      sampled_r <= 1'b0;
    end else begin
      coarse_hold_r <= i_analog_level;
      taken_grp_r <= group_sel_r;
      group_sel_r <= ~group_sel_r;
      sampled_r <= 1'b1;
    end
  end

  // ****************************************
  // Coarse stage
  // ****************************************
  wire [PART_W-1:0] upper_partial_result;
  coarse_stage #(
    .PART_W(PART_W),
    .FRAC_W(FRAC_W),
    .LEVEL_W(LEVEL_W)
  ) u_coarse (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_held_level(coarse_hold_r),
    .o_upper_partial_result_r(upper_partial_result)
  );

  // ****************************************
  // Rising edge 1 and 2 bookkeeping
  // ****************************************
  reg grp1_r;
  reg grp2_r;
  reg [PART_W-1:0] upper2_r;
  reg [`ADC_VALID_W-2:0] valid_pipe_r;
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      grp1_r <= 1'b0;
      grp2_r <= 1'b0;
      upper2_r <= `ADC_PART_ZERO;
      valid_pipe_r <= {(`ADC_VALID_W-1){1'b0}};
    end else begin
      grp1_r <= taken_grp_r;
      grp2_r <= grp1_r;
      upper2_r <= upper_partial_result;
      valid_pipe_r <= {valid_pipe_r[`ADC_VALID_W-3:0], sampled_r};
    end
  end

  // ****************************************
  // Two alternating lower groups
  // ****************************************
  wire [PART_W-1:0] lower_partial_result [0:1];
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_fine
      fine_group #(
        .PART_W(PART_W),
        .FRAC_W(FRAC_W),
        .LEVEL_W(LEVEL_W)
      ) u_fine (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_take(group_sel_r == g),
        .i_level(i_analog_level),
        .i_resolve(grp1_r == g),
        .i_fine_window_reference(upper_partial_result),
        .o_lower_partial_result_r(lower_partial_result[g])
      );
    end
  endgenerate

  // ****************************************
  // Output drive control sync
  // ****************************************
  reg drive_b_meta_r;
  reg drive_b_sync_r;
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drive_b_meta_r <= 1'b1;
      drive_b_sync_r <= 1'b1;
    end else begin
      drive_b_meta_r <= i_output_drive_b;
      drive_b_sync_r <= drive_b_meta_r;
    end
  end

  // ****************************************
  // Rising edge 3: merge and present
  // ****************************************
  wire [CODE_W-1:0] merged_nxt;
  assign merged_nxt = {upper2_r, lower_partial_result[grp2_r]};

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sample_code_bits <= `ADC_CODE_ZERO;
      o_sample_code_bits_oe <= 1'b0;
      o_code_valid <= 1'b0;
    end else begin
      o_sample_code_bits <= merged_nxt;
      o_sample_code_bits_oe <= ~drive_b_sync_r;
      o_code_valid <= valid_pipe_r[`ADC_VALID_W-2];
    end
  end

endmodule

// File: sim/capture_model.sv
// Capture logic model reading the parallel output bus
`timescale 1ns/10ps
module capture_model (
  input wire i_clk_sys,
  input wire [7:0] i_bus,
  output logic [7:0] o_word_r
);
  always @(posedge i_clk_sys) begin
    o_word_r <= i_bus;
  end
endmodule

// File: sim/two_step_adc_output_pipeline_assertions.sv
// Checker for the two-step converter output pipeline
`timescale 1ns/10ps
module two_step_adc_output_pipeline_chk #(
  parameter CODE_W = 8,
  parameter LEVEL_W = 12
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire [LEVEL_W-1:0] i_analog_level,
  input wire i_output_drive_b,
  input wire [CODE_W-1:0] o_sample_code_bits,
  input wire o_sample_code_bits_oe,
  input wire o_code_valid
);
  wire [CODE_W-1:0] lc = i_analog_level[LEVEL_W-1 -: CODE_W];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_fill; !o_code_valid [*3]; endsequence
  sequence s_steady; $stable(i_output_drive_b) [*3]; endsequence
  property p_fill; $rose(i_rst_b) |-> s_fill ##1 o_code_valid; endproperty
  property p_match;
    o_code_valid |-> o_sample_code_bits == $past(lc, 3);
  endproperty
  property p_hold_valid; o_code_valid |=> o_code_valid; endproperty
  property p_new; o_code_valid && $changed(lc) |->
    ##3 $changed(o_sample_code_bits); endproperty
  property p_same; o_code_valid && $stable(lc) |->
    ##3 $stable(o_sample_code_bits); endproperty
  property p_full; o_code_valid && $past(lc, 3) == {CODE_W{1'b1}} |->
    o_sample_code_bits == {CODE_W{1'b1}}; endproperty
  property p_oe_follow; $changed(i_output_drive_b) |->
    ##3 o_sample_code_bits_oe == !$past(i_output_drive_b, 3); endproperty
  property p_oe_steady; s_steady ##0 o_code_valid |->
    o_sample_code_bits_oe == !i_output_drive_b; endproperty
  a_fill: assert property (p_fill)
    else $error("first code not at third rising edge");
  a_match: assert property (p_match)
    else $error("code does not match sample");
  a_hold_valid: assert property (p_hold_valid)
    else $error("valid dropped");
  a_new: assert property (p_new)
    else $error("new sample not delivered");
  a_same: assert property (p_same)
    else $error("code changed without new sample");
  a_full: assert property (p_full)
    else $error("top reference not all ones");
  a_oe_follow: assert property (p_oe_follow)
    else $error("drive enable late or early");
  a_oe_steady: assert property (p_oe_steady)
    else $error("drive enable wrong");
endmodule
bind two_step_adc_output_pipeline two_step_adc_output_pipeline_chk #(
  .CODE_W(CODE_W), .LEVEL_W(LEVEL_W)) chk_i (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
  .i_analog_level(i_analog_level), .i_output_drive_b(i_output_drive_b),
  .o_sample_code_bits(o_sample_code_bits),
  .o_sample_code_bits_oe(o_sample_code_bits_oe),
  .o_code_valid(o_code_valid));

// File: sim/two_step_adc_output_pipeline_tb.sv
// Self-checking testbench for the converter output pipeline
`timescale 1ns/10ps
module two_step_adc_output_pipeline_tb;
  logic i_clk_sys, i_rst_b, i_output_drive_b;
  logic [11:0] i_analog_level;
  logic [7:0] o_sample_code_bits, cap_word;
  logic o_sample_code_bits_oe, o_code_valid;
  wire [7:0] bus;
  int miscompares, cmp_count;
  assign bus = o_sample_code_bits_oe ? o_sample_code_bits : 8'hzz;
  two_step_adc_output_pipeline two_step_adc_output_pipeline_i (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_analog_level(i_analog_level), .i_output_drive_b(i_output_drive_b),
    .o_sample_code_bits(o_sample_code_bits),
    .o_sample_code_bits_oe(o_sample_code_bits_oe),
    .o_code_valid(o_code_valid));
  capture_model capture_model_i (.i_clk_sys(i_clk_sys), .i_bus(bus),
    .o_word_r(cap_word));
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Every code in turn, back to back, fraction varied
  task automatic t_ramp;
    for (int k = 0; k < 260; k++) begin
      if (k >= 3) chk(bus, 8'(k - 3));
      if (k >= 4) chk(cap_word, 8'(k - 4));
      i_analog_level = {8'(k), 4'(k) ^ 4'h5};
      step(1);
    end
    $display("ramp test done");
  endtask
  // Float the bus while the pipeline keeps running
  task automatic t_float;
    i_output_drive_b = 1'b1;
    i_analog_level = 12'h3c7;
    step(2);
    chk({7'h00, o_sample_code_bits_oe}, 8'h01);
    step(1);
    chk(bus, 8'hzz);
    i_output_drive_b = 1'b0;
    step(2);
    chk(bus, 8'hzz);
    step(1);
    chk(bus, 8'h3c);
    $display("float test done");
  endtask
  // Reset in mid-run, then mid-scale first sample
  task automatic t_reset;
    i_rst_b = 1'b0;
    step(2);
    chk(o_sample_code_bits, 8'h00);
    chk({6'h00, o_code_valid, o_sample_code_bits_oe}, 8'h00);
    i_analog_level = 12'h807;
    i_rst_b = 1'b1;
    step(2);
    chk({7'h00, o_code_valid}, 8'h00);
    step(1);
    chk({7'h00, o_code_valid}, 8'h01);
    chk(o_sample_code_bits, 8'h80);
    $display("reset test done");
  endtask
  initial begin
    miscompares = 0;
    cmp_count = 0;
    i_rst_b = 1'b0;
    i_analog_level = 12'h000;
    i_output_drive_b = 1'b0;
    step(20);
    i_rst_b = 1'b1;
    t_ramp;
    t_float;
    t_reset;
    t_ramp;
    report_and_stop;
  end
  initial begin
    repeat (2000) @(posedge i_clk_sys);
    miscompares++;
    report_and_stop;
  end
endmodule
